/* File: core/sdm_pkg.sv */
// Operation
// [RULE1] reference ratio 14 bits, one bypasses, zero illegal
// [RULE2] whole-divide used always; fractional range 36..65535
// [RULE3] integer mode whole-divide 32..65567 via offset
// [RULE4] sub-step unsigned 24 bits, fractional mode only
// [RULE5] fractional mode loads start value as seed
// [RULE6] keying uses start value as first tone
// [RULE7] type code 2 is B, 3 is A
// [RULE8] core release low holds modulator core reset
// [RULE9] buffer release low holds core buffers reset
// [RULE10] output-ignore drops modulator output, keeps clocking
// [RULE11] auto-seed reloads seed on each sub-step write; code reloads only in fractional mode with keying off
// [RULE12] keying enable takes tone from serial data pin
// [RULE13] clock-source bit picks reference or vco divider
// [RULE14] clock-polarity bit inverts selected modulator clock
// [RULE15] four-bit slip correction strength, reset eight
// [RULE16] host writes config bits 12:10 as 011
// [RULE17] frames: six address, 24 data, msb first
// [RULE18] soft-reset strobe at address zero restores defaults
// [RULE19] registers hold value; reserved bits keep defaults
`default_nettype none

package sdm_pkg;
  // ----------------------------------------
  // frame layout
  // ----------------------------------------
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;
  localparam int FRAME_BITS = 1 + ADDR_W + DATA_W;
  localparam int CNT_W = 5;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [5:0] ADDR_SOFT_RESET = 6'h00;
  localparam logic [5:0] ADDR_REF_DIV = 6'h02;
  localparam logic [5:0] ADDR_WHOLE = 6'h03;
  localparam logic [5:0] ADDR_SUB_STEP = 6'h04;
  localparam logic [5:0] ADDR_START = 6'h05;
  localparam logic [5:0] ADDR_CONFIG = 6'h06;
  localparam int SOFT_RESET_BIT = 0;

  // ----------------------------------------
  // widths and reset values
  // ----------------------------------------
  localparam int REF_W = 14;
  localparam int WHOLE_W = 16;
  localparam int RATIO_W = 17;
  localparam logic [13:0] REF_DIV_RST = 14'h0001;
  localparam logic [15:0] WHOLE_RST = 16'h00c8;
  localparam logic [23:0] SUB_STEP_RST = 24'h000000;
  localparam logic [23:0] START_RST = 24'h000000;
  localparam logic [23:0] CONFIG_RST = 24'h842e87;
  // only named fields are writable, reserved bits keep reset value
  localparam logic [23:0] CONFIG_WMASK = 24'hfebf00;
  localparam logic [15:0] INT_OFFSET_LIMIT = 16'h0020;

  // ----------------------------------------
  // config field positions
  // ----------------------------------------
  localparam int CFG_TYPE_LO = 8;
  localparam int CFG_CORE_REL = 10;
  localparam int CFG_BUF_REL = 11;
  localparam int CFG_IGNORE = 12;
  localparam int CFG_AUTOSEED = 13;
  localparam int CFG_KEYING = 15;
  localparam int CFG_CLK_REF = 17;
  localparam int CFG_CLK_INV = 18;
  localparam int CFG_SPARE = 19;
  localparam int CFG_CSP_LO = 20;

  typedef enum logic [1:0] {
    SDM_TYPE_UNUSED0 = 2'h0,
    SDM_TYPE_UNUSED1 = 2'h1,
    SDM_TYPE_B = 2'h2,
    SDM_TYPE_A = 2'h3
  } sdm_type_t;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCK_HALF_NS = 80;
  localparam int SEN_GAP_NS = 640;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEN_GAP_CYC = (SEN_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TCNT_W = 6;
endpackage

`default_nettype wire

/* File: core/sdm_if.sv */
`default_nettype none

interface sdm_if;
  logic sck;
  logic sen;
  logic serial_data_input;

  modport host (output sck, output sen, output serial_data_input);
  modport dev (input sck, input sen, input serial_data_input);
endinterface

`default_nettype wire

/* File: core/sdm_host.sv */
`default_nettype none

module sdm_host (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // serial link
  sdm_if.host link,
  // write request
  input wire logic req,
  input wire logic [5:0] req_addr,
  input wire logic [23:0] req_data,
  output logic ready,
  output logic done,
  // keying tone driven between frames
  input wire logic tone_level
);
  typedef enum {S_IDLE, S_LOW, S_HIGH, S_GAP} sdm_host_state_t;

  sdm_host_state_t state_q;
  logic [sdm_pkg::FRAME_BITS-1:0] shift_q;
  logic [sdm_pkg::CNT_W-1:0] bit_q;
  logic [sdm_pkg::TCNT_W-1:0] tim_q;
  logic sck_q, sen_q, sdi_q, done_q;

  localparam logic [5:0] HALF_LAST = 6'(sdm_pkg::SCK_HALF_CYC - 1);
  localparam logic [5:0] GAP_LAST = 6'(sdm_pkg::SEN_GAP_CYC - 1);
  localparam logic [4:0] BIT_LAST = 5'(sdm_pkg::FRAME_BITS - 1);

  assign ready = (state_q == S_IDLE);
  assign done = done_q;
  assign link.sck = sck_q;
  assign link.sen = sen_q;
  assign link.serial_data_input = sdi_q;

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
      shift_q <= '0;
      bit_q <= '0;
      tim_q <= '0;
      sck_q <= 1'b0;
      sen_q <= 1'b0;
      sdi_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        S_IDLE: begin
          sdi_q <= tone_level; // [RULE12]
          if (req) begin
            // leading zero marks a write, address then data msb first
            shift_q <= {1'b0, req_addr, req_data}; // [RULE17]
            sdi_q <= 1'b0;
            sen_q <= 1'b1;
            bit_q <= '0;
            tim_q <= '0;
            state_q <= S_LOW;
          end
        end
        S_LOW: begin
          if (tim_q == HALF_LAST) begin
            tim_q <= '0;
            sck_q <= 1'b1;
            state_q <= S_HIGH;
          end else begin
            tim_q <= tim_q + 6'h01;
          end
        end
        S_HIGH: begin
          if (tim_q == HALF_LAST) begin
            tim_q <= '0;
            // new bit placed on the falling edge
            sck_q <= 1'b0; // [RULE17]
            if (bit_q == BIT_LAST) begin
              sen_q <= 1'b0;
              state_q <= S_GAP;
            end else begin
              bit_q <= bit_q + 5'h01;
              shift_q <= {shift_q[sdm_pkg::FRAME_BITS-2:0], 1'b0};
              sdi_q <= shift_q[sdm_pkg::FRAME_BITS-2];
              state_q <= S_LOW;
            end
          end else begin
            tim_q <= tim_q + 6'h01;
          end
        end
        S_GAP: begin
          sdi_q <= tone_level;
          if (tim_q == GAP_LAST) begin
            tim_q <= '0;
            done_q <= 1'b1;
            state_q <= S_IDLE;
          end else begin
            tim_q <= tim_q + 6'h01;
          end
        end
      endcase
    end
  end
endmodule

`default_nettype wire

/* File: core/sdm_dev.sv */
`default_nettype none

module sdm_dev (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // serial link
  sdm_if.dev link,
  // divider clocks feeding the modulator clock mux
  input wire logic ref_div_clk,
  input wire logic vco_div_clk,
  // divider settings
  output logic [13:0] ref_div_ratio,
  output logic [16:0] vco_div_ratio,
  output logic [23:0] sub_step_applied,
  // modulator control
  output sdm_pkg::sdm_type_t mod_type,
  output logic mod_core_rst,
  output logic mod_buf_rst,
  output logic mod_output_en,
  output logic frac_mode,
  output logic [23:0] seed_value,
  output logic seed_load,
  output logic keying_en,
  output logic keying_tone,
  output logic mod_clk,
  output logic [3:0] csp_strength,
  output logic modulator_spare_bit,
  // one-cycle pulse for every write frame, mapped or not
  output logic reg_write
);
  // ----------------------------------------
  // link synchronisers
  // ----------------------------------------
  logic sck_m, sck_s, sck_p;
  logic sen_m, sen_s;
  logic sdi_m, sdi_s;
  logic sck_rise;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_p <= 1'b0;
      sen_m <= 1'b0;
      sen_s <= 1'b0;
      sdi_m <= 1'b0;
      sdi_s <= 1'b0;
    end else begin
      sck_m <= link.sck;
      sck_s <= sck_m;
      sck_p <= sck_s;
      sen_m <= link.sen;
      sen_s <= sen_m;
      sdi_m <= link.serial_data_input;
      sdi_s <= sdi_m;
    end
  end

  // sck and sdi take the same delay, so the bit is stable at the edge
  assign sck_rise = sck_s && !sck_p;

  // ----------------------------------------
  // frame shifter
  // ----------------------------------------
  logic [sdm_pkg::FRAME_BITS-2:0] shift_q;
  logic [sdm_pkg::CNT_W-1:0] cnt_q;
  logic [sdm_pkg::FRAME_BITS-1:0] frame_w;
  logic wr_w;
  logic [5:0] waddr_w;
  logic [23:0] wdata_w;
  localparam logic [4:0] CNT_LAST = 5'(sdm_pkg::FRAME_BITS - 1);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      shift_q <= '0;
      cnt_q <= '0;
    end else if (!sen_s) begin
      cnt_q <= '0;
    end else if (sck_rise && cnt_q != CNT_LAST + 5'h01) begin
      shift_q <= {shift_q[sdm_pkg::FRAME_BITS-3:0], sdi_s}; // [RULE17]
      cnt_q <= cnt_q + 5'h01;
    end
  end

  assign frame_w = {shift_q, sdi_s};
  // a leading one is a read, which this end ignores
  assign wr_w = sen_s && sck_rise && (cnt_q == CNT_LAST) && !frame_w[30]; // [RULE17]
  assign waddr_w = frame_w[29:24];
  assign wdata_w = frame_w[23:0];

  logic soft_rst_w;
  assign soft_rst_w = wr_w && waddr_w == sdm_pkg::ADDR_SOFT_RESET &&
                      wdata_w[sdm_pkg::SOFT_RESET_BIT]; // [RULE18]

  function automatic logic hit(input logic [5:0] a);
    hit = wr_w && (waddr_w == a);
  endfunction

  // ----------------------------------------
  // register bank
  // ----------------------------------------
  logic [13:0] ref_q;
  logic [15:0] whole_q;
  logic [23:0] sub_q, start_q, cfg_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ref_q <= sdm_pkg::REF_DIV_RST;
    end else if (soft_rst_w) begin
      ref_q <= sdm_pkg::REF_DIV_RST; // [RULE18]
    end else if (hit(sdm_pkg::ADDR_REF_DIV)) begin
      ref_q <= wdata_w[13:0]; // [RULE1] [RULE19]
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      whole_q <= sdm_pkg::WHOLE_RST;
    end else if (soft_rst_w) begin
      whole_q <= sdm_pkg::WHOLE_RST; // [RULE18]
    end else if (hit(sdm_pkg::ADDR_WHOLE)) begin
      whole_q <= wdata_w[15:0]; // [RULE2] [RULE19]
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sub_q <= sdm_pkg::SUB_STEP_RST;
    end else if (soft_rst_w) begin
      sub_q <= sdm_pkg::SUB_STEP_RST; // [RULE18]
    end else if (hit(sdm_pkg::ADDR_SUB_STEP)) begin
      sub_q <= wdata_w; // [RULE4] [RULE19]
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      start_q <= sdm_pkg::START_RST;
    end else if (soft_rst_w) begin
      start_q <= sdm_pkg::START_RST; // [RULE18]
    end else if (hit(sdm_pkg::ADDR_START)) begin
      start_q <= wdata_w; // [RULE19]
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= sdm_pkg::CONFIG_RST;
    end else if (soft_rst_w) begin
      cfg_q <= sdm_pkg::CONFIG_RST; // [RULE18]
    end else if (hit(sdm_pkg::ADDR_CONFIG)) begin
      cfg_q <= (wdata_w & sdm_pkg::CONFIG_WMASK) |
               (sdm_pkg::CONFIG_RST & ~sdm_pkg::CONFIG_WMASK); // [RULE19]
    end
  end

  // ----------------------------------------
  // decoded modes
  // ----------------------------------------
  logic core_rel_w, buf_rel_w, ignore_w, frac_w, keying_w;
  assign core_rel_w = cfg_q[sdm_pkg::CFG_CORE_REL];
  assign buf_rel_w = cfg_q[sdm_pkg::CFG_BUF_REL];
  assign ignore_w = cfg_q[sdm_pkg::CFG_IGNORE];
  // fractional only with core and buffers released and output used
  assign frac_w = core_rel_w && buf_rel_w && !ignore_w; // [RULE16]
  assign keying_w = cfg_q[sdm_pkg::CFG_KEYING];

  // tone sampled only between frames; the pin is shared with data
  logic tone_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tone_q <= 1'b0;
    end else if (keying_w && !sen_s) begin
      tone_q <= sdi_s; // [RULE12]
    end
  end

  // seed reload in fractional mode with keying off, on auto-seed sub-step write or when the core leaves reset
  logic core_rel_p, seed_load_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      core_rel_p <= 1'b1;
      seed_load_q <= 1'b0;
    end else begin
      core_rel_p <= core_rel_w;
      seed_load_q <= frac_w && !keying_w && (
        (cfg_q[sdm_pkg::CFG_AUTOSEED] && hit(sdm_pkg::ADDR_SUB_STEP)) || // [RULE11]
        (core_rel_w && !core_rel_p)); // [RULE5]
    end
  end

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  logic [16:0] ratio_d;
  always_comb begin
    ratio_d = {1'b0, whole_q};
    // low stored values in integer mode reach 65536..65567
    if (!frac_w && whole_q < sdm_pkg::INT_OFFSET_LIMIT) begin
      ratio_d = {1'b1, whole_q}; // [RULE3]
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ref_div_ratio <= sdm_pkg::REF_DIV_RST;
      vco_div_ratio <= {1'b0, sdm_pkg::WHOLE_RST};
      sub_step_applied <= '0;
      seed_value <= sdm_pkg::START_RST;
      mod_type <= sdm_pkg::SDM_TYPE_B;
      mod_core_rst <= 1'b0;
      mod_buf_rst <= 1'b0;
      mod_output_en <= 1'b1;
      frac_mode <= 1'b1;
      keying_en <= 1'b0;
      keying_tone <= 1'b0;
      csp_strength <= sdm_pkg::CONFIG_RST[23:20];
      modulator_spare_bit <= 1'b0;
      reg_write <= 1'b0;
    end else begin
      ref_div_ratio <= ref_q; // [RULE1]
      vco_div_ratio <= ratio_d; // [RULE2]
      if (!frac_w) begin
        sub_step_applied <= '0; // [RULE4] [RULE10]
      end else if (keying_w && tone_q) begin
        sub_step_applied <= start_q; // [RULE6]
      end else begin
        sub_step_applied <= sub_q; // [RULE4]
      end
      seed_value <= start_q; // [RULE5]
      mod_type <= sdm_pkg::sdm_type_t'(cfg_q[9:8]); // [RULE7]
      mod_core_rst <= !core_rel_w; // [RULE8]
      mod_buf_rst <= !buf_rel_w; // [RULE9]
      mod_output_en <= !ignore_w; // [RULE10]
      frac_mode <= frac_w;
      keying_en <= keying_w; // [RULE12]
      keying_tone <= tone_q;
      csp_strength <= cfg_q[23:20]; // [RULE15]
      modulator_spare_bit <= cfg_q[sdm_pkg::CFG_SPARE];
      reg_write <= wr_w;
    end
  end

  assign seed_load = seed_load_q;

  // ----------------------------------------
  // modulator clock mux
  // ----------------------------------------
  // a glitch is possible when the select changes; change it with the core held
  logic mod_src_w;
  assign mod_src_w = cfg_q[sdm_pkg::CFG_CLK_REF] ? ref_div_clk : vco_div_clk; // [RULE13]
  assign mod_clk = mod_src_w ^ cfg_q[sdm_pkg::CFG_CLK_INV]; // [RULE14]
endmodule

`default_nettype wire

/* File: test/sdm_props.sv */
`default_nettype none

module sdm_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // serial link
  input wire logic sck,
  input wire logic sen,
  input wire logic serial_data_input,
  // device status
  input wire logic reg_write,
  input wire logic frac_mode,
  input wire logic mod_core_rst,
  input wire logic mod_buf_rst,
  input wire logic mod_output_en
);
  timeunit 1ns;
  timeprecision 100ps;

  logic sck_q;
  logic [5:0] cnt_q;
  logic [5:0] gap_q;
  logic [29:0] sh_q;
  logic hit;

  // ----------------------------------------
  // frame tracking
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sck_q <= 1'b0;
      cnt_q <= 6'h00;
      sh_q <= 30'h00000000;
    end else begin
      sck_q <= sck;
      if (!sen) cnt_q <= 6'h00;
      else if (sck && !sck_q) cnt_q <= cnt_q + 6'h01;
      if (sen && sck && !sck_q) sh_q <= {sh_q[28:0], serial_data_input};
    end
  end

  // starts saturated so the first frame after reset is not flagged
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) gap_q <= 6'h3f;
    else if (sen) gap_q <= 6'h00;
    else if (gap_q != 6'h3f) gap_q <= gap_q + 6'h01;
  end

  // write frame to address 0 or 2..6
  assign hit = !sh_q[29] && (sh_q[28:23] == 6'h00 ||
               (sh_q[28:23] >= 6'h02 && sh_q[28:23] <= 6'h06));

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_open;
    !sen ##1 sen;
  endsequence
  sequence s_last_rise;
    sen && $rose(sck) && cnt_q == 6'h1e;
  endsequence

  a_sck_idle_low: assert property (!sen |-> !sck)
    else $error("sck high outside a frame");
  a_sdi_on_fall: assert property (sen && $past(sen) && $changed(serial_data_input) |-> $fell(sck))
    else $error("sdi changed away from a falling sck");
  a_sck_high_len: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
    else $error("sck high phase not four cycles");
  a_write_bit_first: assert property (s_open |-> (!serial_data_input)[*5])
    else $error("frame did not open with a write bit");
  a_frame_bit_count: assert property ($fell(sen) |-> cnt_q == 6'h1f)
    else $error("frame closed without 31 rising edges");
  a_frame_gap_min: assert property (s_open |-> gap_q >= 6'h20)
    else $error("frame gap shorter than 32 cycles");
  a_write_commit: assert property (s_last_rise ##0 hit |-> ##[1:8] reg_write)
    else $error("mapped write not committed");
  a_write_single: assert property (reg_write |=> !reg_write)
    else $error("write pulse longer than one cycle");
  a_frac_mode_set: assert property (frac_mode |-> !mod_core_rst && !mod_buf_rst && mod_output_en)
    else $error("fractional mode with core held or output dropped");
endmodule

`default_nettype wire

/* File: test/tb_top.sv */
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, e); end end

  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic req = 1'b0;
  logic [5:0] req_addr = 6'h00;
  logic [23:0] req_data = 24'h000000;
  logic tone_level = 1'b0;
  logic ref_div_clk = 1'b0;
  logic vco_div_clk = 1'b0;
  logic ready, done, mod_core_rst, mod_buf_rst, mod_output_en, frac_mode;
  logic seed_load, keying_en, keying_tone, mod_clk, modulator_spare_bit, reg_write;
  // pulse counts, written only by the sampling process below
  int n_seed = 0;
  int n_wr = 0;
  int mark = 0;
  logic [13:0] ref_div_ratio;
  logic [16:0] vco_div_ratio;
  logic [23:0] sub_step_applied, seed_value;
  logic [3:0] csp_strength;
  sdm_pkg::sdm_type_t mod_type;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;

  sdm_if link_if ();
  sdm_host u_sdm_host (.sys_clk, .rstn, .link(link_if), .req, .req_addr, .req_data,
    .ready, .done, .tone_level);
  sdm_dev u_sdm_dev (.sys_clk, .rstn, .link(link_if), .ref_div_clk, .vco_div_clk,
    .ref_div_ratio, .vco_div_ratio, .sub_step_applied, .mod_type, .mod_core_rst,
    .mod_buf_rst, .mod_output_en, .frac_mode, .seed_value, .seed_load, .keying_en,
    .keying_tone, .mod_clk, .csp_strength, .modulator_spare_bit, .reg_write);
  sdm_props u_props (.sys_clk, .rstn, .sck(link_if.sck), .sen(link_if.sen),
    .serial_data_input(link_if.serial_data_input), .reg_write, .frac_mode, .mod_core_rst, .mod_buf_rst,
    .mod_output_en);

  always #10 sys_clk = ~sys_clk;

  // pulses are counted so a check after the write still sees them
  always @(posedge sys_clk) begin
    cyc++;
    if (seed_load === 1'b1) n_seed++;
    if (reg_write === 1'b1) n_wr++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    int i;
    i = 0;
    while (ready !== 1'b1 && i < 600) begin
      @(negedge sys_clk);
      i++;
    end
    if (i == 600) bad_count++;
    req = 1'b1;
    req_addr = a;
    req_data = d;
    @(negedge sys_clk);
    req = 1'b0;
    i = 0;
    while (done !== 1'b1 && i < 600) begin
      @(negedge sys_clk);
      i++;
    end
    if (i == 600) bad_count++;
  endtask

  task automatic chk_def();
    `CHK(ref_div_ratio, 14'h0001)
    `CHK(vco_div_ratio, 17'h000c8)
    `CHK(sub_step_applied, 24'h000000)
    `CHK(seed_value, 24'h000000)
    `CHK(mod_type, sdm_pkg::SDM_TYPE_B)
    `CHK(({mod_core_rst, mod_buf_rst, mod_output_en, frac_mode}), 4'h3)
    `CHK(({keying_en, modulator_spare_bit}), 2'h0)
    `CHK(csp_strength, 4'h8)
  endtask

  task automatic clk_chk(input logic r, input logic v, input logic e);
    ref_div_clk = r;
    vco_div_clk = v;
    #1;
    `CHK(mod_clk, e)
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(negedge sys_clk);
    rstn = 1'b1;
    chk_def();
    wr(6'h02, 24'h003fff);
    `CHK(ref_div_ratio, 14'h3fff)
    wr(6'h02, 24'hffc001);
    `CHK(ref_div_ratio, 14'h0001)
    wr(6'h02, 24'h000010);
    wr(6'h03, 24'h00ffff);
    `CHK(vco_div_ratio, 17'h0ffff)
    wr(6'h03, 24'h000024);
    `CHK(vco_div_ratio, 17'h00024)
    `CHK(ref_div_ratio, 14'h0010)
    // integer mode, type A, weakest slip correction
    wr(6'h06, 24'h042387);
    `CHK(mod_type, sdm_pkg::SDM_TYPE_A)
    `CHK(({csp_strength, mod_core_rst, mod_buf_rst, mod_output_en, frac_mode}), 8'h0e)
    wr(6'h03, 24'h00001f);
    `CHK(vco_div_ratio, 17'h1001f)
    wr(6'h03, 24'h000020);
    `CHK(vco_div_ratio, 17'h00020)
    wr(6'h04, 24'h123456);
    `CHK(sub_step_applied, 24'h000000)
    wr(6'h06, 24'h842a87);
    `CHK(({mod_core_rst, mod_buf_rst, frac_mode}), 3'h4)
    wr(6'h06, 24'h843e87);
    `CHK(({mod_core_rst, mod_buf_rst, mod_output_en, sub_step_applied}), 27'h0000000)
    // fractional mode, reference clock, no inversion
    wr(6'h06, 24'hfa2e87);
    `CHK(({frac_mode, modulator_spare_bit, csp_strength}), 6'h3f)
    `CHK(sub_step_applied, 24'h123456)
    clk_chk(1'b1, 1'b0, 1'b1);
    clk_chk(1'b0, 1'b1, 1'b0);
    wr(6'h06, 24'h842e87);
    clk_chk(1'b0, 1'b1, 1'b0);
    clk_chk(1'b1, 1'b0, 1'b1);
    wr(6'h05, 24'habcdef);
    `CHK(seed_value, 24'habcdef)
    mark = n_seed;
    wr(6'h04, 24'hffffff);
    `CHK(({(n_seed != mark), sub_step_applied}), 25'h1ffffff)
    wr(6'h06, 24'h840e87);
    mark = n_seed;
    wr(6'h04, 24'h000001);
    `CHK(({(n_seed != mark), sub_step_applied}), 25'h0000001)
    // core held, then released in fractional mode: one seed load
    wr(6'h06, 24'h840a87);
    mark = n_seed;
    wr(6'h06, 24'h840e87);
    `CHK((n_seed - mark), 1)
    // two-tone keying from the serial data line between frames
    wr(6'h06, 24'h84ae87);
    tone_level = 1'b1;
    repeat (8) @(negedge sys_clk);
    `CHK(({keying_en, keying_tone, sub_step_applied}), 26'h3abcdef)
    tone_level = 1'b0;
    repeat (8) @(negedge sys_clk);
    `CHK(({keying_en, keying_tone, sub_step_applied}), 26'h2000001)
    // every write frame pulses reg_write, unmapped ones change nothing
    mark = n_wr;
    wr(6'h01, 24'h000000);
    wr(6'h07, 24'h000000);
    wr(6'h3f, 24'h000000);
    `CHK(({((n_wr - mark) == 3), ref_div_ratio}), 15'h4010)
    wr(6'h00, 24'h000001);
    chk_def();
    end_of_test();
  end

`undef CHK
endmodule

`default_nettype wire
